// >>> dv/crs_clk_sink.sv
`timescale 1ns/1ns
module crs_clk_sink (
    input wire     refclk_out_first,  // Clock the board relies on
    input wire     refclk_out_second, // Optional second clock
    output integer n_first = 0,       // Rising edges seen
    output integer n_second = 0       // Rising edges seen
);
    always @(posedge refclk_out_first) n_first <= n_first + 1;
    always @(posedge refclk_out_second) n_second <= n_second + 1;
endmodule

// >>> dv/crs_refclk_select_sva.sv
`timescale 1ns/1ns
module crs_refclk_select_sva #(
    parameter QUAD_VARIANT = 1             // Same variant as the design
) (
    input wire        clk_sys,             // Reference clock
    input wire        reset,               // Synchronous, active high
    input wire        power_down_pin,      // Power-down pin
    input wire        reg_read,            // Read strobe
    input wire        reg_write,           // Write strobe
    input wire        refclk_out_first,    // First reference output
    input wire [3:0]  reg_addr,            // Register address
    input wire [31:0] reg_rdata,           // Read data
    input wire [31:0] reg_wdata,           // Write data
    input wire [1:0]  refclk_out_en        // Output drivers enabled
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Marks the cycle that carries status read data
    reg st = 1'b0;
    always @(posedge clk_sys) st <= reg_read && reg_addr == 4'h4;
    pd_off_a: assert property (
        power_down_pin[*3] |=> refclk_out_en == 2'h0)
        else $error("outputs enabled during power-down");
    out_gate_a: assert property (
        !refclk_out_en[0] |-> !refclk_out_first)
        else $error("first output active while disabled");
    unmapped_read_a: assert property (
        reg_read && reg_addr[3] |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_rb_a: assert property (
        reg_write && reg_addr == 4'h0 ##1 !reg_write ##1 reg_read && reg_addr == 4'h0
        |=> reg_rdata == {26'h0, $past(reg_wdata[5:0], 3)})
        else $error("control readback differs");
    sec_dep_a: assert property (
        st && reg_rdata[3:2] == 2'h0 |-> reg_rdata[5:4] == 2'h0)
        else $error("second clock without first");
    pd_st_a: assert property (
        st && reg_rdata[8] |-> reg_rdata[7:2] == 6'h0)
        else $error("function active in power-down");
    ovr_pri_a: assert property (
        st && reg_rdata[6] |-> reg_rdata[3:2] == 2'h0)
        else $error("over-range beside a clock");
endmodule
bind crs_refclk_select crs_refclk_select_sva #(.QUAD_VARIANT(QUAD_VARIANT)) sva (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .power_down_pin   (power_down_pin),
    .reg_read         (reg_read),
    .reg_write        (reg_write),
    .refclk_out_first (refclk_out_first),
    .reg_addr         (reg_addr),
    .reg_rdata        (reg_rdata),
    .reg_wdata        (reg_wdata),
    .refclk_out_en    (refclk_out_en)
);

// >>> dv/crs_refclk_select_tb.sv
`timescale 1ns/1ns
module crs_refclk_select_tb;
    reg         clk_sys = 0, reset = 1, power_down_pin = 0, reg_write = 0, reg_read = 0;
    reg  [1:0]  clock_strap_pins = 0, overrange_flag = 0;
    reg  [3:0]  reg_addr = 0;
    reg  [31:0] reg_wdata = 0;
    wire [31:0] reg_rdata;
    wire [1:0]  refclk_out_en;
    wire        refclk_out_first, refclk_out_second;
    integer     n_fail = 0, n_checks = 0, n_first, n_second, c, d, i;
    always #5 clk_sys = ~clk_sys;
    crs_refclk_select dut (
        .clk_sys           (clk_sys),
        .reset             (reset),
        .clock_strap_pins  (clock_strap_pins),
        .power_down_pin    (power_down_pin),
        .overrange_flag    (overrange_flag),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_write         (reg_write),
        .reg_read          (reg_read),
        .reg_rdata         (reg_rdata),
        .refclk_out_first  (refclk_out_first),
        .refclk_out_second (refclk_out_second),
        .refclk_out_en     (refclk_out_en)
    );
    crs_clk_sink sink (
        .refclk_out_first  (refclk_out_first),
        .refclk_out_second (refclk_out_second),
        .n_first           (n_first),
        .n_second          (n_second)
    );
    task chk(input [31:0] g, e); begin
        n_checks = n_checks + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0t %h %h", $time, g, e);
        end
    end endtask
    task bus(input w, input [3:0] a, input [31:0] v); begin
        @(posedge clk_sys) {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, a, v};
        @(posedge clk_sys) {reg_write, reg_read} <= 0;
        @(negedge clk_sys) if (!w) chk(reg_rdata, v);
    end endtask
    // Counts edges over 40 cycles, after the 3-edge strap/mode latency
    task meas(input integer e, f); begin
        repeat (4) @(negedge clk_sys) {c, d} = {n_first, n_second};
        repeat (40) @(negedge clk_sys);
        chk(n_first - c, e);
        chk(n_second - d, f);
    end endtask
    task straps; for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk_sys) clock_strap_pins <= i;
        meas(i ? 40 >> (i - 1) : 0, i ? 40 : 0);
        chk(refclk_out_en, {i != 0, i != 0});
        bus(0, 4, {i != 0, i[1:0], i[1:0]});
    end endtask
    task override; for (i = 0; i < 4; i = i + 1) begin
        bus(1, 0, {24'hffffff, 2'h3, i[1:0], 2'h1});
        bus(0, 0, {2'h3, i[1:0], 2'h1});
        meas(i ? 40 >> (i - 1) : 0, i ? 10 : 0);
    end endtask
    task overrange; begin
        @(posedge clk_sys) overrange_flag <= 2'h3;
        bus(1, 0, 32'h3);
        bus(0, 8, 32'h0);
        bus(0, 4, 32'hc3);
        @(negedge clk_sys) chk({refclk_out_second, refclk_out_first}, 2'h3);
        @(posedge clk_sys) overrange_flag <= 2'h1;
        @(negedge clk_sys) chk({refclk_out_second, refclk_out_first}, 2'h1);
        bus(1, 0, 32'h7);
        bus(0, 4, 'h87);
    end endtask
    task powerdown; begin
        @(posedge clk_sys) power_down_pin <= 1;
        meas(0, 0);
        bus(0, 4, 'h103);
    end endtask
    task conclude; begin
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (!n_fail && n_checks) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end endtask
    initial begin
        repeat (20) @(posedge clk_sys) reset <= 1;
        reset <= 0;
        straps;
        override;
        overrange;
        powerdown;
        conclude;
    end
    initial #100000 begin n_fail = n_fail + 1; conclude; end
endmodule

// >>> logic/crs_consts.vh
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH

`define CRS_ADDR_CTRL       4'h0
`define CRS_ADDR_STATUS     4'h4

`define CRS_CTRL_OVR_BIT    0
`define CRS_CTRL_ORE_BIT    1
`define CRS_CTRL_FM_LSB     2
`define CRS_CTRL_SM_LSB     4
`define CRS_CTRL_RESET      6'h00

`define CRS_MODE_OFF        2'h0
`define CRS_MODE_REF        2'h1
`define CRS_MODE_DIV2       2'h2
`define CRS_MODE_DIV4       2'h3

`define CRS_STAT_STRAP_LSB  0
`define CRS_STAT_FM_LSB     2
`define CRS_STAT_SM_LSB     4
`define CRS_STAT_FOR_BIT    6
`define CRS_STAT_SOR_BIT    7
`define CRS_STAT_PD_BIT     8

`define CRS_STRAP_RESET     2'h0
`define CRS_PD_RESET        1'h1
`define CRS_MODE_RESET      4'h0
`define CRS_OVR_RESET       2'h0
`define CRS_SEL_RESET       1'h0
`define CRS_EN_RESET        2'h0
`define CRS_DIV_RESET       2'h0
`define CRS_RDATA_RESET     32'h0

`endif

// >>> logic/crs_refclk_select.v
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "crs_consts.vh"

module crs_refclk_select #(
    parameter QUAD_VARIANT = 1                // 1: four-channel part, over-range usable
) (
    input  wire        clk_sys,               // Reference clock, 100 MHz
    input  wire        reset,                 // Synchronous, active high
    input  wire [1:0]  clock_strap_pins,      // Configuration straps, asynchronous
    input  wire        power_down_pin,        // Power-down pin, asynchronous
    input  wire [1:0]  overrange_flag,        // Over-range per output, same clock
    input  wire [3:0]  reg_addr,              // Register byte address
    input  wire [31:0] reg_wdata,             // Register write data
    input  wire        reg_write,             // Write strobe
    input  wire        reg_read,              // Read strobe
    output reg  [31:0] reg_rdata,             // Read data, cycle after strobe
    output wire        refclk_out_first,      // First CMOS reference output
    output wire        refclk_out_second,     // Second CMOS reference output
    output reg  [1:0]  refclk_out_en          // Output drivers enabled, per output
);

    reg  [1:0]  strap_meta;
    reg  [1:0]  strap_sync;
    reg         pd_meta;
    reg         pd_sync;
    reg         pd_applied;
    reg  [5:0]  ctrl;
    reg  [1:0]  div_cnt;
    reg  [3:0]  mode_q;
    reg  [1:0]  ovr_q;
    reg  [1:0]  strap_first;
    reg  [1:0]  strap_second;
    reg  [1:0]  req_first;
    reg  [1:0]  req_second;
    reg  [3:0]  next_mode;
    reg  [1:0]  next_ovr;
    reg  [31:0] ctrl_word;
    reg  [31:0] status_word;
    reg  [31:0] next_rdata;
    wire        strap_override_enable;
    wire        overrange_output_enable;
    wire [1:0]  first_out_mode_field;
    wire [1:0]  second_out_mode_field;
    wire [1:0]  gated_out;

    assign strap_override_enable   = ctrl[`CRS_CTRL_OVR_BIT];
    assign overrange_output_enable = ctrl[`CRS_CTRL_ORE_BIT];
    assign first_out_mode_field    = ctrl[`CRS_CTRL_FM_LSB+1:`CRS_CTRL_FM_LSB];
    assign second_out_mode_field   = ctrl[`CRS_CTRL_SM_LSB+1:`CRS_CTRL_SM_LSB];

    // Straps are board pins: two flops before any decode
    always @(posedge clk_sys) begin
        if (reset) begin
            strap_meta <= `CRS_STRAP_RESET;
            strap_sync <= `CRS_STRAP_RESET;
        end else begin
            strap_meta <= clock_strap_pins;
            strap_sync <= strap_meta;
        end
    end

    // Resets high so the outputs stay quiet until the pin is seen low
    always @(posedge clk_sys) begin
        if (reset) begin
            pd_meta <= `CRS_PD_RESET;
            pd_sync <= `CRS_PD_RESET;
        end else begin
            pd_meta <= power_down_pin;
            pd_sync <= pd_meta;
        end
    end

    // Override defaults clear, so straps rule from power-up
    always @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= `CRS_CTRL_RESET;
        end else if (reg_write && reg_addr == `CRS_ADDR_CTRL) begin
            ctrl <= reg_wdata[5:0];
        end
    end

    // Straps can only switch the second output; its divider is register-only
    always @* begin
        case (strap_sync)
            `CRS_MODE_OFF: begin
                strap_first  = `CRS_MODE_OFF;
                strap_second = `CRS_MODE_OFF;
            end
            `CRS_MODE_REF: begin
                strap_first  = `CRS_MODE_REF;
                strap_second = `CRS_MODE_REF;
            end
            `CRS_MODE_DIV2: begin
                strap_first  = `CRS_MODE_DIV2;
                strap_second = `CRS_MODE_REF;
            end
            `CRS_MODE_DIV4: begin
                strap_first  = `CRS_MODE_DIV4;
                strap_second = `CRS_MODE_REF;
            end
            default: begin
                strap_first  = `CRS_MODE_OFF;
                strap_second = `CRS_MODE_OFF;
            end
        endcase
    end

    always @* begin
        if (strap_override_enable) begin
            req_first  = first_out_mode_field;
            req_second = second_out_mode_field;
        end else begin
            req_first  = strap_first;
            req_second = strap_second;
        end
    end

    // Effective mode per output; power-down overrides everything
    always @* begin
        next_mode[1:0] = req_first;
        next_mode[3:2] = req_second;
        next_ovr       = 2'h0;
        if (req_first == `CRS_MODE_OFF) begin
            next_mode[3:2] = `CRS_MODE_OFF;
        end
        if (QUAD_VARIANT != 0 && overrange_output_enable) begin
            next_ovr[0] = (next_mode[1:0] == `CRS_MODE_OFF);
            next_ovr[1] = (next_mode[3:2] == `CRS_MODE_OFF);
        end
        if (pd_sync) begin
            next_mode = 4'h0;
            next_ovr  = 2'h0;
        end
    end

    // Mode, over-range and power-down fields share one stage; the strap field is strap_sync, one stage earlier
    always @* begin
        ctrl_word      = `CRS_RDATA_RESET;
        ctrl_word[5:0] = ctrl;
        status_word    = `CRS_RDATA_RESET;
        status_word[`CRS_STAT_STRAP_LSB+1:`CRS_STAT_STRAP_LSB] = strap_sync;
        status_word[`CRS_STAT_FM_LSB+1:`CRS_STAT_FM_LSB]       = mode_q[1:0];
        status_word[`CRS_STAT_SM_LSB+1:`CRS_STAT_SM_LSB]       = mode_q[3:2];
        status_word[`CRS_STAT_FOR_BIT] = ovr_q[0];
        status_word[`CRS_STAT_SOR_BIT] = ovr_q[1];
        status_word[`CRS_STAT_PD_BIT]  = pd_applied;
    end

    always @* begin
        next_rdata = `CRS_RDATA_RESET;
        if (reg_read) begin
            case (reg_addr)
                `CRS_ADDR_CTRL:   next_rdata = ctrl_word;
                `CRS_ADDR_STATUS: next_rdata = status_word;
                default:          next_rdata = `CRS_RDATA_RESET;
            endcase
        end
    end

    // Read data stands one cycle, zero otherwise
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= `CRS_RDATA_RESET;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Power-down copy kept in step with the mode it forced
    always @(posedge clk_sys) begin
        if (reset) begin
            mode_q        <= `CRS_MODE_RESET;
            ovr_q         <= `CRS_OVR_RESET;
            pd_applied    <= `CRS_PD_RESET;
            refclk_out_en <= `CRS_EN_RESET;
        end else begin
            mode_q        <= next_mode;
            ovr_q         <= next_ovr;
            pd_applied    <= pd_sync;
            refclk_out_en <= {next_mode[3:2] != `CRS_MODE_OFF || next_ovr[1],
                              next_mode[1:0] != `CRS_MODE_OFF || next_ovr[0]};
        end
    end

    // Free-running divider; phase is not aligned to a mode change
    always @(posedge clk_sys) begin
        if (reset) begin
            div_cnt <= `CRS_DIV_RESET;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_out
            reg sel_ref;
            reg sel_div2;
            reg sel_div4;
            reg sel_ovr;

            // One-hot selects keep wide compares out of the clock path
            always @(posedge clk_sys) begin
                if (reset) begin
                    sel_ref  <= `CRS_SEL_RESET;
                    sel_div2 <= `CRS_SEL_RESET;
                    sel_div4 <= `CRS_SEL_RESET;
                    sel_ovr  <= `CRS_SEL_RESET;
                end else begin
                    sel_ref  <= (next_mode[2*i+1:2*i] == `CRS_MODE_REF);
                    sel_div2 <= (next_mode[2*i+1:2*i] == `CRS_MODE_DIV2);
                    sel_div4 <= (next_mode[2*i+1:2*i] == `CRS_MODE_DIV4);
                    sel_ovr  <= next_ovr[i];
                end
            end

            // Undivided path gates the clock itself; a mode change may clip one pulse
            assign gated_out[i] = (sel_ref  && clk_sys)    ||
                                  (sel_div2 && div_cnt[0]) ||
                                  (sel_div4 && div_cnt[1]) ||
                                  (sel_ovr  && overrange_flag[i]);
        end
    endgenerate

    assign refclk_out_first  = gated_out[0];
    assign refclk_out_second = gated_out[1];

endmodule
